//--- hdl/wwdt_defines.vh
// constants for the window watchdog supervisor logic
// Summary of operation
// - Between power-on level and minimum operating level, reset output is held low.
// - While reset is asserted the fault output floats, kick activity ignored.
// - Reset output follows the supply monitor alone; reset floats the fault output.
// - Pin pulled up or open selects factory windows; capacitor selects capacitor timing.
// - Open pin, enabled: lower window 800 ms, upper window 1600 ms typical.
// - Pulled-up pin, enabled: lower window 1.85 ms, upper window 11.0 ms typical.
// - Capacitor mode: constant current charges pin until threshold ends the interval.
// - Capacitor mode: upper window seconds = 77.4 times microfarads plus 0.055.
// - Capacitor mode: lower window is half the upper window; analog spread 0.85-1.15.
// - Only a falling edge on the kick input counts as a service event.
// - After enable or reset release, first kick accepted anytime before upper window; the code ignores kicks during the 100 us setup time.
// - Later kicks before lower or none before upper window drive the fault low.
// - Enable pin low disables watchdog, ignores kicks, floats fault output.
`ifndef WWDT_DEFINES_VH
`define WWDT_DEFINES_VH

// clock rate
`define WWDT_CLK_MHZ 25
`define WWDT_US_PER_MS 1000

// factory windows
`define WWDT_OPEN_LOWER_MS 800
`define WWDT_OPEN_UPPER_MS 1600
`define WWDT_PULL_LOWER_US 1850
`define WWDT_PULL_UPPER_US 11000

// capacitor timing: slope in ms per uF, source current, pin threshold
`define WWDT_CAP_SLOPE_MS_PER_UF 77400
`define WWDT_CAP_OFFSET_MS 55
`define WWDT_CHARGE_NA 375
`define WWDT_THRESH_MV 1210
`define WWDT_CAP_NUM (`WWDT_CAP_SLOPE_MS_PER_UF * `WWDT_CHARGE_NA)
`define WWDT_CAP_DEN (`WWDT_THRESH_MV * `WWDT_US_PER_MS)

// timing pin probe phases
`define WWDT_DISCH_US 20
`define WWDT_SETTLE_US 10
`define WWDT_OPEN_PROBE_US 10
`define WWDT_DISCH_CYC (`WWDT_DISCH_US * `WWDT_CLK_MHZ)
`define WWDT_SETTLE_CYC (`WWDT_SETTLE_US * `WWDT_CLK_MHZ)
`define WWDT_OPEN_PROBE_CYC (`WWDT_OPEN_PROBE_US * `WWDT_CLK_MHZ)

// enable setup time and fault hold time
`define WWDT_SETUP_US 100
`define WWDT_SETUP_CYC (`WWDT_SETUP_US * `WWDT_CLK_MHZ)
`define WWDT_FAULT_HOLD_MS 200

// timing pin modes
`define WWDT_MODE_OPEN 2'h0
`define WWDT_MODE_PULL 2'h1
`define WWDT_MODE_CAP 2'h2

`endif

//--- hdl/wwdt_pin_probe.v
// timing pin probe: detects pin configuration and measures capacitor charge time
`timescale 1ns/100ps
`include "wwdt_defines.vh"

module wwdt_pin_probe (
  // clock and reset
  input wire mclk_in,
  input wire rstn_in,
  // control
  input wire start_in,
  // pin comparator, high when pin voltage reaches threshold
  input wire pin_high_in,
  // pin drive and result
  output wire charge_out,
  output wire discharge_out,
  output wire done_out,
  output wire [1:0] mode_out,
  output wire [27:0] count_out
);

  localparam [2:0] P_IDLE = 3'h0;
  localparam [2:0] P_DISCH = 3'h1;
  localparam [2:0] P_SETTLE = 3'h2;
  localparam [2:0] P_OPEN = 3'h3;
  localparam [2:0] P_CHARGE = 3'h4;
  // phase lengths cut to the counter width on purpose
  localparam integer DISCH_INT = `WWDT_DISCH_CYC;
  localparam integer SETTLE_INT = `WWDT_SETTLE_CYC;
  localparam integer OPEN_INT = `WWDT_OPEN_PROBE_CYC;
  localparam [27:0] DISCH_CYC = DISCH_INT[27:0];
  localparam [27:0] SETTLE_CYC = SETTLE_INT[27:0];
  localparam [27:0] OPEN_CYC = OPEN_INT[27:0];

  reg [2:0] state_ff, nxt_state;
  reg [27:0] cnt_ff, nxt_cnt;
  reg [27:0] count_ff, nxt_count;
  reg [1:0] mode_ff, nxt_mode;
  reg charge_ff, nxt_charge;
  reg disch_ff, nxt_disch;
  reg done_ff, nxt_done;

  // probe sequence; a restart in any phase begins a fresh discharge
  always @*
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff + 28'h1;
    nxt_count = count_ff;
    nxt_mode = mode_ff;
    nxt_charge = charge_ff;
    nxt_disch = disch_ff;
    nxt_done = 1'b0;
    if (start_in)
    begin
      nxt_state = P_DISCH;
      nxt_cnt = 28'h0;
      nxt_charge = 1'b0;
      nxt_disch = 1'b1;
    end
    else
    begin
      case (state_ff)
        P_IDLE:
        begin
          nxt_cnt = 28'h0;
        end
        P_DISCH:
        begin
          if (cnt_ff >= DISCH_CYC - 28'h1)
          begin
            nxt_state = P_SETTLE;
            nxt_cnt = 28'h0;
            nxt_disch = 1'b0;
          end
        end
        P_SETTLE:
        begin
          // a pin that rises with no source must be pulled up
          if (cnt_ff >= SETTLE_CYC - 28'h1)
          begin
            nxt_cnt = 28'h0;
            if (pin_high_in)
            begin
              nxt_state = P_IDLE;
              nxt_mode = `WWDT_MODE_PULL;
              nxt_done = 1'b1;
            end
            else
            begin
              nxt_state = P_OPEN;
              nxt_charge = 1'b1;
            end
          end
        end
        P_OPEN:
        begin
          // only parasitic load charges this fast, so the pin is open
          if (pin_high_in)
          begin
            nxt_state = P_IDLE;
            nxt_mode = `WWDT_MODE_OPEN;
            nxt_charge = 1'b0;
            nxt_done = 1'b1;
          end
          else if (cnt_ff >= OPEN_CYC - 28'h1)
            nxt_state = P_CHARGE;
        end
        P_CHARGE:
        begin
          // count runs on from the open probe; saturation ends an oversize cap
          if (pin_high_in || (&cnt_ff))
          begin
            nxt_state = P_IDLE;
            nxt_mode = `WWDT_MODE_CAP;
            nxt_count = cnt_ff;
            nxt_charge = 1'b0;
            nxt_disch = 1'b1;
            nxt_done = 1'b1;
          end
        end
        default:
        begin
          nxt_state = P_IDLE;
        end
      endcase
    end
  end

  // probe registers
  always @(posedge mclk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      state_ff <= P_IDLE;
      cnt_ff <= 28'h0;
      count_ff <= 28'h0;
      mode_ff <= `WWDT_MODE_OPEN;
      charge_ff <= 1'b0;
      disch_ff <= 1'b0;
      done_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      count_ff <= nxt_count;
      mode_ff <= nxt_mode;
      charge_ff <= nxt_charge;
      disch_ff <= nxt_disch;
      done_ff <= nxt_done;
    end
  end

  assign charge_out = charge_ff;
  assign discharge_out = disch_ff;
  assign done_out = done_ff;
  assign mode_out = mode_ff;
  assign count_out = count_ff;

endmodule

//--- hdl/wwdt_top.v
// window watchdog supervisor: reset output, window timing and fault output
`timescale 1ns/100ps
`include "wwdt_defines.vh"

module wwdt_top #(
  parameter [31:0] OPEN_LOWER_CYC = `WWDT_OPEN_LOWER_MS * `WWDT_US_PER_MS * `WWDT_CLK_MHZ,
  parameter [31:0] OPEN_UPPER_CYC = `WWDT_OPEN_UPPER_MS * `WWDT_US_PER_MS * `WWDT_CLK_MHZ,
  parameter [31:0] PULL_LOWER_CYC = `WWDT_PULL_LOWER_US * `WWDT_CLK_MHZ,
  parameter [31:0] PULL_UPPER_CYC = `WWDT_PULL_UPPER_US * `WWDT_CLK_MHZ,
  parameter [31:0] CAP_OFFSET_CYC = `WWDT_CAP_OFFSET_MS * `WWDT_US_PER_MS * `WWDT_CLK_MHZ,
  parameter [31:0] FAULT_HOLD_CYC = `WWDT_FAULT_HOLD_MS * `WWDT_US_PER_MS * `WWDT_CLK_MHZ
) (
  // clock and reset
  input wire mclk_in,
  input wire rstn_in,
  // supply monitor comparators
  input wire supply_above_min_in,
  input wire supply_above_thresh_in,
  // processor side
  input wire kick_input_in,
  input wire watchdog_enable_pin_in,
  // timing pin comparator
  input wire timing_pin_high_in,
  // timing pin drivers
  output wire timing_pin_charge_out,
  output wire timing_pin_discharge_out,
  // open-drain reset output
  output wire reset_n_out,
  output wire reset_oe_out,
  // open-drain watchdog fault output
  output wire watchdog_fault_n_out,
  output wire watchdog_fault_oe_out,
  // status
  output wire [1:0] window_mode_out
);

  localparam [2:0] ST_PROBE = 3'h0;
  localparam [2:0] ST_OFF = 3'h1;
  localparam [2:0] ST_SETUP = 3'h2;
  localparam [2:0] ST_FIRST = 3'h3;
  localparam [2:0] ST_WIN = 3'h4;
  localparam [2:0] ST_FAULT = 3'h5;
  localparam [31:0] SETUP_CYC = `WWDT_SETUP_CYC;

  reg [2:0] state_ff, nxt_state;
  reg [31:0] cnt_ff, nxt_cnt;
  reg [31:0] lower_ff, nxt_lower;
  reg [31:0] upper_ff, nxt_upper;
  reg [1:0] mode_ff, nxt_mode;
  reg fault_oe_ff, nxt_fault_oe;
  reg fault_n_ff;
  reg reset_n_ff;
  reg reset_oe_ff;
  reg reset_d_ff;
  reg kick_d_ff;

  wire probe_done;
  wire [1:0] probe_mode;
  wire [27:0] probe_count;
  wire [55:0] cap_scaled;
  wire [31:0] cap_upper;
  wire kick_fall;
  wire probe_start;
  wire enabled;

  // the probe restarts each time the supply reset is released
  assign probe_start = reset_n_ff & ~reset_d_ff;

  wwdt_pin_probe u_probe (
    .mclk_in(mclk_in),
    .rstn_in(rstn_in),
    .start_in(probe_start),
    .pin_high_in(timing_pin_high_in),
    .charge_out(timing_pin_charge_out),
    .discharge_out(timing_pin_discharge_out),
    .done_out(probe_done),
    .mode_out(probe_mode),
    .count_out(probe_count)
  );

  // charge time to upper window: slope scaled by source current over threshold
  assign cap_scaled = ({28'h0, probe_count} * `WWDT_CAP_NUM) / `WWDT_CAP_DEN;
  assign cap_upper = cap_scaled[31:0] + CAP_OFFSET_CYC;

  // only a high-to-low transition of the kick pin is a service event
  assign kick_fall = kick_d_ff & ~kick_input_in;
  assign enabled = watchdog_enable_pin_in;

  // window boundaries latched once the pin configuration is known
  always @*
  begin
    nxt_lower = lower_ff;
    nxt_upper = upper_ff;
    nxt_mode = mode_ff;
    if (probe_done)
    begin
      nxt_mode = probe_mode;
      case (probe_mode)
        `WWDT_MODE_PULL:
        begin
          nxt_lower = PULL_LOWER_CYC;
          nxt_upper = PULL_UPPER_CYC;
        end
        `WWDT_MODE_CAP:
        begin
          // spread is analog tolerance; the typical value is what is timed
          nxt_lower = {1'b0, cap_upper[31:1]};
          nxt_upper = cap_upper;
        end
        default:
        begin
          nxt_lower = OPEN_LOWER_CYC;
          nxt_upper = OPEN_UPPER_CYC;
        end
      endcase
    end
  end

  // watchdog sequence
  always @*
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff + 32'h1;
    nxt_fault_oe = fault_oe_ff;
    if (!reset_n_ff)
    begin
      // supply reset floats the fault pin and ignores kicks
      nxt_state = ST_PROBE;
      nxt_cnt = 32'h0;
      nxt_fault_oe = 1'b0;
    end
    else if (state_ff != ST_PROBE && !enabled)
    begin
      nxt_state = ST_OFF;
      nxt_cnt = 32'h0;
      nxt_fault_oe = 1'b0;
    end
    else
    begin
      case (state_ff)
        ST_PROBE:
        begin
          nxt_cnt = 32'h0;
          nxt_fault_oe = 1'b0;
          if (probe_done)
            nxt_state = enabled ? ST_SETUP : ST_OFF;
        end
        ST_OFF:
        begin
          // re-enable passes through setup with the count from zero
          nxt_cnt = 32'h0;
          nxt_state = ST_SETUP;
        end
        ST_SETUP:
        begin
          // kicks in the setup time are not looked at
          if (cnt_ff >= SETUP_CYC - 32'h1)
          begin
            nxt_state = ST_FIRST;
            nxt_cnt = 32'h0;
          end
        end
        ST_FIRST:
        begin
          // first kick has no lower bound
          if (kick_fall)
          begin
            nxt_state = ST_WIN;
            nxt_cnt = 32'h0;
          end
          else if (cnt_ff >= upper_ff - 32'h1)
          begin
            nxt_state = ST_FAULT;
            nxt_cnt = 32'h0;
            nxt_fault_oe = 1'b1;
          end
        end
        ST_WIN:
        begin
          if (kick_fall)
          begin
            nxt_cnt = 32'h0;
            if (cnt_ff < lower_ff)
            begin
              nxt_state = ST_FAULT;
              nxt_fault_oe = 1'b1;
            end
          end
          else if (cnt_ff >= upper_ff - 32'h1)
          begin
            nxt_state = ST_FAULT;
            nxt_cnt = 32'h0;
            nxt_fault_oe = 1'b1;
          end
        end
        ST_FAULT:
        begin
          // hold the fault long enough to be seen, then start over as a first kick
          if (cnt_ff >= FAULT_HOLD_CYC - 32'h1)
          begin
            nxt_state = ST_FIRST;
            nxt_cnt = 32'h0;
            nxt_fault_oe = 1'b0;
          end
        end
        default:
        begin
          nxt_state = ST_PROBE;
          nxt_cnt = 32'h0;
          nxt_fault_oe = 1'b0;
        end
      endcase
    end
  end

  // supply reset from the comparators alone
  always @(posedge mclk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      reset_n_ff <= 1'b0;
      reset_oe_ff <= 1'b1;
      reset_d_ff <= 1'b0;
    end
    else
    begin
      reset_n_ff <= supply_above_min_in & supply_above_thresh_in;
      reset_oe_ff <= ~(supply_above_min_in & supply_above_thresh_in);
      reset_d_ff <= reset_n_ff;
    end
  end

  // watchdog registers
  always @(posedge mclk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      state_ff <= ST_PROBE;
      cnt_ff <= 32'h0;
      lower_ff <= 32'h0;
      upper_ff <= 32'h0;
      mode_ff <= `WWDT_MODE_OPEN;
      fault_oe_ff <= 1'b0;
      fault_n_ff <= 1'b1;
      kick_d_ff <= 1'b1;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      lower_ff <= nxt_lower;
      upper_ff <= nxt_upper;
      mode_ff <= nxt_mode;
      fault_oe_ff <= nxt_fault_oe;
      fault_n_ff <= ~nxt_fault_oe; // driven low only when enabled
      kick_d_ff <= kick_input_in;
    end
  end

  assign reset_n_out = reset_n_ff;
  assign reset_oe_out = reset_oe_ff;
  assign watchdog_fault_n_out = fault_n_ff;
  assign watchdog_fault_oe_out = fault_oe_ff;
  assign window_mode_out = mode_ff;

endmodule

//--- verif/wwdt_pin_model.sv
// timing pin fitting model: pull-up, open pin or capacitor
`timescale 1ns/100ps
module wwdt_pin_model #(
  parameter integer OPEN_RISE = 20,
  parameter integer CAP_RISE = 300
) (
  // clock and fitting select
  input wire mclk_in,
  input wire [1:0] fit_in,
  // pin drive and comparator
  input wire charge_in,
  input wire discharge_in,
  output wire pin_high_out
);
  reg [15:0] level_ff = 16'h0000;
  // current source ramps the pin, switch empties it; capacitor kept in range
  always @(posedge mclk_in)
  begin
    if (discharge_in)
      level_ff <= 16'h0000;
    else if (charge_in)
      level_ff <= level_ff + 16'h0001;
  end
  // pull-up reads high unless shorted; open pin has little charge to fill
  assign pin_high_out = (fit_in == 2'h1) ? !discharge_in :
    (level_ff >= ((fit_in == 2'h0) ? OPEN_RISE : CAP_RISE));
endmodule

//--- verif/wwdt_top_properties.sv
// port-level checks for the window watchdog supervisor
`timescale 1ns/100ps
module wwdt_top_properties (
  // clock and reset
  input wire mclk_in,
  input wire rstn_in,
  // inputs
  input wire supply_above_min_in,
  input wire supply_above_thresh_in,
  input wire watchdog_enable_pin_in,
  input wire timing_pin_high_in,
  // outputs
  input wire timing_pin_charge_out,
  input wire timing_pin_discharge_out,
  input wire reset_n_out,
  input wire watchdog_fault_n_out,
  input wire watchdog_fault_oe_out
);
  default clocking dc @(posedge mclk_in);
  endclocking
  default disable iff (!rstn_in);
  // supply release, then the pin probe two edges on
  sequence s_release;
    $rose(reset_n_out);
  endsequence
  sequence s_probe;
    ##2 timing_pin_discharge_out;
  endsequence
  // not started on the release edge, where the flop still shows chip reset
  a_reset_follow: assert property (rstn_in |=>
    reset_n_out == $past(supply_above_min_in && supply_above_thresh_in))
    else $error("reset output not following supply");
  a_low_supply: assert property (!supply_above_min_in |=> !reset_n_out)
    else $error("reset released below operating level");
  a_reset_floats: assert property ((!reset_n_out && $past(!reset_n_out))
    |-> !watchdog_fault_oe_out)
    else $error("fault driven during reset");
  a_fault_pair: assert property (watchdog_fault_n_out != watchdog_fault_oe_out)
    else $error("fault value and enable disagree");
  a_disable_float: assert property (!watchdog_enable_pin_in |=> !watchdog_fault_oe_out)
    else $error("fault driven while disabled");
  a_fault_cause: assert property ($rose(watchdog_fault_oe_out) |->
    $past(watchdog_enable_pin_in) && $past(reset_n_out))
    else $error("fault raised while inactive");
  a_probe_start: assert property (s_release |-> s_probe)
    else $error("pin probe did not begin");
  a_charge_stop: assert property (timing_pin_charge_out && timing_pin_high_in
    |-> ##[1:3] !timing_pin_charge_out)
    else $error("charging past threshold");
  a_charge_excl: assert property (!(timing_pin_charge_out && timing_pin_discharge_out))
    else $error("charge and discharge together");
endmodule

bind wwdt_top wwdt_top_properties wwdt_top_properties_inst (
  .mclk_in(mclk_in),
  .rstn_in(rstn_in),
  .supply_above_min_in(supply_above_min_in),
  .supply_above_thresh_in(supply_above_thresh_in),
  .watchdog_enable_pin_in(watchdog_enable_pin_in),
  .timing_pin_high_in(timing_pin_high_in),
  .timing_pin_charge_out(timing_pin_charge_out),
  .timing_pin_discharge_out(timing_pin_discharge_out),
  .reset_n_out(reset_n_out),
  .watchdog_fault_n_out(watchdog_fault_n_out),
  .watchdog_fault_oe_out(watchdog_fault_oe_out)
);

//--- verif/window_watchdog_timing_tb.sv
// self-checking testbench for the window watchdog supervisor
`timescale 1ns/100ps
module window_watchdog_timing_tb;
  // shortened windows and fault hold, in clock cycles
  localparam integer PULL_LO = 20;
  localparam integer PULL_UP = 60;
  localparam integer OPEN_LO = 40;
  localparam integer OPEN_UP = 80;
  localparam integer CAP_OFS = 10;
  localparam integer HOLD = 30;
  // capacitor upper window: 300 charge cycles scaled, plus offset
  localparam integer CAP_UP = (300 * 29025) / 1210 + CAP_OFS;
  reg mclk_in = 1'b0;
  reg rstn_in = 1'b0;
  reg sup_min = 1'b1;
  reg sup_thr = 1'b1;
  reg kick = 1'b1;
  reg wd_en = 1'b1;
  reg [1:0] pin_mode = 2'h1;
  // fault cycles counted; a scenario notes the count to start afresh
  integer fault_cnt = 0;
  integer fault_base = 0;
  wire fault_seen = (fault_cnt != fault_base);
  wire pin_high, chg, dis, rst_n, fault_oe, rst_oe, fault_n;
  wire [1:0] mode;
  integer n_fail = 0;
  integer num_checks = 0;
  wwdt_top #(.OPEN_LOWER_CYC(OPEN_LO), .OPEN_UPPER_CYC(OPEN_UP), .PULL_LOWER_CYC(PULL_LO),
    .PULL_UPPER_CYC(PULL_UP), .CAP_OFFSET_CYC(CAP_OFS), .FAULT_HOLD_CYC(HOLD)) wwdt_top_inst (
    .mclk_in(mclk_in), .rstn_in(rstn_in), .supply_above_min_in(sup_min),
    .supply_above_thresh_in(sup_thr), .kick_input_in(kick), .watchdog_enable_pin_in(wd_en),
    .timing_pin_high_in(pin_high), .timing_pin_charge_out(chg),
    .timing_pin_discharge_out(dis), .reset_n_out(rst_n), .reset_oe_out(rst_oe),
    .watchdog_fault_n_out(fault_n), .watchdog_fault_oe_out(fault_oe), .window_mode_out(mode));
  wwdt_pin_model wwdt_pin_model_inst (.mclk_in(mclk_in), .fit_in(pin_mode), .charge_in(chg),
    .discharge_in(dis), .pin_high_out(pin_high));
  // clock
  initial
  begin
    forever #20 mclk_in = ~mclk_in;
  end
  // one writer for the count, so scenarios never race the flag
  always @(posedge mclk_in)
    if (fault_oe === 1'b1) fault_cnt <= fault_cnt + 1;
  task chk(input [1:0] got, input [1:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp)
      begin
        n_fail = n_fail + 1;
        $display("Error at %0t: got %0h expected %0h", $time, got, exp);
      end
    end
  endtask
  task cyc(input integer n);
    begin
      repeat (n) @(posedge mclk_in);
    end
  endtask
  // falling edges gap cycles apart; rising edges in between must not count
  task kicks(input integer n, input integer gap);
    integer i;
    begin
      for (i = 0; i < n; i = i + 1)
      begin
        cyc(gap - 2);
        kick <= 1'b0;
        cyc(2);
        kick <= 1'b1;
      end
    end
  endtask
  task restart(input [1:0] m);
    begin
      rstn_in <= 1'b0;
      pin_mode <= m;
      cyc(4);
      rstn_in <= 1'b1;
      fault_base = fault_cnt;
    end
  endtask
  // kick stream through setup, then a missed kick and an early kick
  task t_window(input [1:0] m, input integer lo, input integer up, input integer gap);
    integer mg;
    begin
      mg = up / 8;
      restart(m);
      kicks(3600 / gap + 4, gap);
      chk(mode, m);
      chk(fault_seen, 1'b0);
      cyc(up - mg - 2);
      chk(fault_seen, 1'b0);
      cyc(2 * mg);
      chk(fault_seen, 1'b1);
      cyc(HOLD + 1);
      fault_base = fault_cnt;
      kicks(2, gap);
      chk(fault_seen, 1'b0);
      kicks(1, lo - mg);
      cyc(3);
      chk(fault_seen, 1'b1);
    end
  endtask
  // supply reset floats a standing fault and ignores kicks
  task t_float;
    begin
      restart(2'h1);
      kicks(92, 40);
      kicks(1, 10);
      cyc(3);
      chk(fault_oe, 1'b1);
      chk({rst_oe, fault_n}, 2'h0);
      sup_thr <= 1'b0;
      cyc(3);
      chk({rst_n, fault_oe}, 2'h0);
      chk({rst_oe, fault_n}, 2'h3);
      sup_min <= 1'b0;
      sup_thr <= 1'b1;
      fault_base = fault_cnt;
      kicks(20, 10);
      chk({rst_n, fault_seen}, 2'h0);
      sup_min <= 1'b1;
      cyc(2);
      chk(rst_n, 1'b1);
    end
  endtask
  // disabled watchdog ignores kicks and drops a fault at once
  task t_disable;
    begin
      wd_en <= 1'b0;
      restart(2'h1);
      kicks(100, 10);
      chk(fault_seen, 1'b0);
      wd_en <= 1'b1;
      kicks(70, 40);
      chk(fault_seen, 1'b0);
      kicks(1, 10);
      cyc(3);
      chk(fault_oe, 1'b1);
      wd_en <= 1'b0;
      cyc(2);
      chk(fault_oe, 1'b0);
      chk(fault_n, 1'b1);
    end
  endtask
  task end_of_test;
    begin
      $display("checks %0d errors %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  // hang guard, well past the expected run length
  initial
  begin
    cyc(80000);
    n_fail = n_fail + 1;
    end_of_test;
  end
  initial
  begin
    t_window(2'h1, PULL_LO, PULL_UP, 40);
    t_window(2'h0, OPEN_LO, OPEN_UP, 60);
    t_window(2'h2, CAP_UP / 2, CAP_UP, 5400);
    t_float;
    t_disable;
    end_of_test;
  end
endmodule
